/* File: seq_pkg.sv */
// constants and types shared by the instruction sequencer files
package seq_pkg;

    // ------------------------------------------------------------
    // widths and sizes
    // ------------------------------------------------------------
    localparam int PC_W = 11;
    localparam int DATA_W = 8;
    localparam int INSN_W = 14;
    localparam int STACK_DEPTH = 4;
    localparam int STACK_AW = 2;

    // ------------------------------------------------------------
    // reset values and vectors
    // ------------------------------------------------------------
    localparam logic [10:0] RESET_VECTOR = 11'h000;
    localparam logic [10:0] INT_VECTOR_DEFAULT = 11'h004;
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [3:0] FLAGS_RESET = 4'h0;
    localparam logic CTL_RESET = 1'b0;

    // ------------------------------------------------------------
    // register offsets (byte addresses) and field positions
    // ------------------------------------------------------------
    localparam logic [3:0] OFS_PC_LOW = 4'h0;
    localparam logic [3:0] OFS_STATUS = 4'h4;
    localparam logic [3:0] OFS_CONTROL = 4'h8;
    localparam logic [3:0] OFS_ACC = 4'hC;
    localparam int ST_C = 0;
    localparam int ST_AC = 1;
    localparam int ST_Z = 2;
    localparam int ST_OV = 3;
    localparam int ST_PHASE = 4;
    localparam int ST_PEND = 6;
    localparam int CTL_IE = 0;

    // ------------------------------------------------------------
    // instruction classes and sub-codes
    // ------------------------------------------------------------
    localparam logic [1:0] OPC_ALU = 2'b00;
    localparam logic [1:0] OPC_BRANCH = 2'b01;
    localparam logic [1:0] OPC_SKIP = 2'b10;
    localparam logic [1:0] OPC_MISC = 2'b11;
    localparam logic [1:0] SK_ZERO = 2'b00;
    localparam logic [1:0] SK_NONZERO = 2'b01;
    localparam logic [1:0] SK_INC_ZERO = 2'b10;
    localparam logic [1:0] SK_DEC_ZERO = 2'b11;
    localparam logic [1:0] MISC_NOP = 2'b00;
    localparam logic [1:0] MISC_SUB_RETURN = 2'b01;
    localparam logic [1:0] MISC_INT_RETURN = 2'b10;
    localparam logic [1:0] MISC_ACC_TO_PC = 2'b11;

    typedef enum logic [3:0] {
        FN_ADD = 4'h0, FN_ADC = 4'h1, FN_SUB = 4'h2, FN_SBC = 4'h3,
        FN_DECADJ = 4'h4, FN_AND = 4'h5, FN_OR = 4'h6, FN_XOR = 4'h7,
        FN_CPL = 4'h8, FN_RR = 4'h9, FN_RRC = 4'hA, FN_RL = 4'hB,
        FN_RLC = 4'hC, FN_INC = 4'hD, FN_DEC = 4'hE, FN_MOV = 4'hF
    } alu_fn_type;

    typedef enum logic [1:0] {
        PH_FETCH = 2'b00,
        PH_DECODE = 2'b01,
        PH_EXEC = 2'b10,
        PH_WRITE = 2'b11
    } phase_type;

endpackage

/* File: stack_mem.sv */
// small return-address memory with registered read data
`timescale 1ns/1ns
`default_nettype none
module stack_mem #(
    parameter int WIDTH = 11,
    parameter int DEPTH = 4,
    parameter int AW = 2
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic [AW-1:0] rd_addr,
    output logic [WIDTH-1:0] rd_data
);

    logic [WIDTH-1:0] mem [DEPTH];

    // array write, no reset on the storage itself
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // read data always comes out of a register
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_data <= '0;
        end else begin
            rd_data <= mem[rd_addr];
        end
    end

endmodule
`default_nettype wire

/* File: fetch_sequencer.sv */
// four-phase fetch and execute sequencer with hidden stack and alu
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - clock splits into four non-overlapping phases; fetch starts at first
// - next fetch overlaps current execute; one instruction per cycle
// - control transfers take two instruction cycles
// - counter steps by one unless control moves elsewhere
// - jump, call, interrupt and reset load target into counter
// - taken skip discards prefetched word and runs a dummy cycle
// - counter low byte readable, writable; write jumps in page, dummy
// - four-level stack holds counter values only, hidden from software
// - call or interrupt pushes counter; returns pop it back
// - reset leaves the stack empty
// - full stack holds interrupt pending until a return pops
// - call on full stack runs and loses the oldest entry
// - eight-bit alu writes its result and updates status flags
// - alu covers arithmetic, decimal adjust, logic, rotate, inc, dec
// - program memory of 2K 14-bit words addressed by counter
// - execution begins at address zero after reset
module fetch_sequencer
    import seq_pkg::*;
#(
    parameter logic [PC_W-1:0] INT_VECTOR = INT_VECTOR_DEFAULT
) (
    input wire logic MCLK,
    input wire logic ARST_N,
    input wire logic [3:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    output logic [PC_W-1:0] PM_ADDR,
    input wire logic [INSN_W-1:0] PM_DATA,
    output logic [3:0] PHASE_CLK,
    input wire logic INT_REQ,
    output logic INT_ACK
);

    // ------------------------------------------------------------
    // alu
    // ------------------------------------------------------------
    // returns {ov, z, ac, c, result}
    function automatic logic [11:0] alu(input alu_fn_type fn,
        input logic [7:0] a, input logic [7:0] b, input logic [3:0] f);
        logic sub;
        logic cin;
        logic [7:0] bb;
        logic [8:0] s;
        logic [4:0] h;
        logic [8:0] d;
        logic [7:0] r;
        logic c;
        logic ac;
        logic ov;
        sub = (fn == FN_SUB) || (fn == FN_SBC);
        cin = (fn == FN_SUB) || ((fn == FN_ADC || fn == FN_SBC) && f[ST_C]);
        bb = sub ? ~b : b;
        s = {1'b0, a} + {1'b0, bb} + {8'h00, cin};
        h = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, cin};
        d = {1'b0, a};
        r = a;
        c = f[ST_C];
        ac = f[ST_AC];
        ov = f[ST_OV];
        case (fn)
            FN_ADD, FN_ADC, FN_SUB, FN_SBC: begin
                r = s[7:0];
                c = s[8]; // carry set means no borrow on subtract
                ac = h[4];
                ov = (a[7] == bb[7]) && (s[7] != a[7]);
            end
            FN_DECADJ: begin
                if (a[3:0] > 4'h9 || f[ST_AC]) begin
                    d = d + 9'h006;
                end
                if (d[7:4] > 4'h9 || f[ST_C] || d[8]) begin
                    d = d + 9'h060;
                end
                r = d[7:0];
                c = d[8] | f[ST_C];
            end
            FN_AND: r = a & b;
            FN_OR: r = a | b;
            FN_XOR: r = a ^ b;
            FN_CPL: r = ~a;
            FN_RR: r = {a[0], a[7:1]};
            FN_RRC: begin
                r = {f[ST_C], a[7:1]};
                c = a[0];
            end
            FN_RL: r = {a[6:0], a[7]};
            FN_RLC: begin
                r = {a[6:0], f[ST_C]};
                c = a[7];
            end
            FN_INC: r = a + 8'h01;
            FN_DEC: r = a - 8'h01;
            FN_MOV: r = b;
            default: r = a;
        endcase
        return {ov, (r == 8'h00), ac, c, r};
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    phase_type phase_q;
    phase_type phase_d;
    logic [3:0] phase_oh_q;
    logic [PC_W-1:0] pc_q;
    logic [PC_W-1:0] pc_d;
    logic [PC_W-1:0] ir_pc_q;
    logic [INSN_W-1:0] ir_q;
    logic ir_valid_q;
    logic [7:0] acc_q;
    logic [7:0] acc_d;
    logic [3:0] flags_q;
    logic [3:0] flags_d;
    logic ie_q;
    logic ie_d;
    logic pend_q;
    logic ack_q;
    logic pcl_pend_q;
    logic [7:0] pcl_val_q;
    logic [2:0] depth_q;
    logic [2:0] depth_d;
    logic [STACK_AW-1:0] wp_q;
    logic [STACK_AW-1:0] wp_d;
    logic [PC_W-1:0] stack_top;
    logic wait_q;
    logic [31:0] rdata_q;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    wire logic boundary = (phase_q == PH_WRITE);
    wire logic [1:0] cls = ir_q[13:12];
    wire logic stack_full = (depth_q == 3'(STACK_DEPTH));
    wire logic pcl_apply = boundary && pcl_pend_q;
    wire logic int_take = boundary && pend_q && ie_q && ir_valid_q &&
        !stack_full && !pcl_pend_q;
    wire logic exec = boundary && ir_valid_q && !int_take;
    wire logic is_alu = exec && (cls == OPC_ALU);
    wire logic is_jump = exec && (cls == OPC_BRANCH) && !ir_q[11];
    wire logic is_call = exec && (cls == OPC_BRANCH) && ir_q[11];
    wire logic is_skip = exec && (cls == OPC_SKIP);
    wire logic is_misc = exec && (cls == OPC_MISC);
    wire logic is_sub_rtn = is_misc && (ir_q[1:0] == MISC_SUB_RETURN);
    wire logic is_int_rtn = is_misc && (ir_q[1:0] == MISC_INT_RETURN);
    wire logic is_acc_pc = is_misc && (ir_q[1:0] == MISC_ACC_TO_PC);
    wire logic is_pop = is_sub_rtn || is_int_rtn;
    wire logic is_push = int_take || is_call;

    // skip ops reuse the alu: test, increment or decrement the accumulator
    wire alu_fn_type fn = !is_skip ? alu_fn_type'(ir_q[11:8]) :
        (ir_q[9:8] == SK_INC_ZERO) ? FN_INC :
        (ir_q[9:8] == SK_DEC_ZERO) ? FN_DEC : FN_MOV;
    wire logic [7:0] operand = is_skip ? acc_q : ir_q[7:0];
    wire logic [11:0] alu_out = alu(fn, acc_q, operand, flags_q);
    wire logic res_zero = (alu_out[7:0] == 8'h00);
    wire logic skip_take = is_skip &&
        ((ir_q[9:8] == SK_NONZERO) ? !res_zero : res_zero);

    // any change of flow that throws away the prefetched word
    wire logic redirect = pcl_apply || int_take || is_jump || is_call ||
        is_acc_pc || is_pop || skip_take;

    // ------------------------------------------------------------
    // next values
    // ------------------------------------------------------------
    // phase sequencing, one instruction cycle per four clocks
    assign phase_d = phase_type'(phase_q + 2'b01);

    // counter selection; page writes keep the upper bits
    assign pc_d = !boundary ? pc_q :
        pcl_apply ? {pc_q[PC_W-1:8], pcl_val_q} :
        int_take ? INT_VECTOR :
        (is_jump || is_call) ? ir_q[PC_W-1:0] :
        is_acc_pc ? {pc_q[PC_W-1:8], acc_q} :
        is_pop ? stack_top :
        pc_q + 11'h001;

    // accumulator and flags from the alu
    assign acc_d = (is_alu || (is_skip && ir_q[9])) ?
        alu_out[7:0] : acc_q;
    assign flags_d = is_alu ? alu_out[11:8] : flags_q;

    // circular stack: overflow overwrites the oldest entry
    assign wp_d = is_push ? wp_q + 2'b01 :
        is_pop ? wp_q - 2'b01 : wp_q;
    assign depth_d = (is_push && !stack_full) ? depth_q + 3'b001 :
        (is_pop && depth_q != 3'b000) ? depth_q - 3'b001 : depth_q;

    // interrupt enable: entry clears, interrupt return sets
    wire logic ctl_wr;
    assign ie_d = int_take ? 1'b0 : is_int_rtn ? 1'b1 :
        ctl_wr ? AVS_WRITEDATA[CTL_IE] : ie_q;

    // ------------------------------------------------------------
    // pipeline registers
    // ------------------------------------------------------------
    // phase counter and its one-hot phase clocks
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            phase_q <= PH_FETCH;
            phase_oh_q <= 4'h1;
        end else begin
            phase_q <= phase_d;
            phase_oh_q <= 4'h1 << phase_d;
        end
    end

    // fetch address and instruction register; fetch overlaps execute
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            pc_q <= RESET_VECTOR;
            ir_q <= '0;
            ir_pc_q <= RESET_VECTOR;
            ir_valid_q <= 1'b0;
        end else begin
            pc_q <= pc_d;
            if (boundary) begin
                ir_q <= PM_DATA;
                ir_pc_q <= pc_q;
                ir_valid_q <= !redirect;
            end
        end
    end

    // datapath and stack bookkeeping
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            acc_q <= ACC_RESET;
            flags_q <= FLAGS_RESET;
            depth_q <= 3'b000;
            wp_q <= '0;
        end else begin
            acc_q <= acc_d;
            flags_q <= flags_d;
            depth_q <= depth_d;
            wp_q <= wp_d;
        end
    end

    // interrupt request latch; a new request beats the acknowledge clear
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            pend_q <= 1'b0;
            ack_q <= 1'b0;
            ie_q <= CTL_RESET;
        end else begin
            pend_q <= INT_REQ | (pend_q & !int_take);
            ack_q <= int_take;
            ie_q <= ie_d;
        end
    end

    // ------------------------------------------------------------
    // return-address stack
    // ------------------------------------------------------------
    // interrupt entry saves the address of the word it displaced
    stack_mem #(
        .WIDTH(PC_W),
        .DEPTH(STACK_DEPTH),
        .AW(STACK_AW)
    ) u_stack (
        .clk(MCLK),
        .arst_n(ARST_N),
        .wr_en(is_push),
        .wr_addr(wp_q),
        .wr_data(int_take ? ir_pc_q : pc_q),
        .rd_addr(wp_q - 2'b01),
        .rd_data(stack_top)
    );

    // ------------------------------------------------------------
    // register bus slave
    // ------------------------------------------------------------
    wire logic req = AVS_READ | AVS_WRITE;
    wire logic pcl_sel = (AVS_ADDRESS == OFS_PC_LOW);
    wire logic accept = req && wait_q && !(AVS_WRITE && pcl_sel && pcl_pend_q);
    wire logic wr_now = AVS_WRITE && !wait_q;
    assign ctl_wr = wr_now && (AVS_ADDRESS == OFS_CONTROL);

    // read mux; the stack and its pointer have no path here
    wire logic [31:0] rd_mux =
        pcl_sel ? {24'h000000, pc_q[7:0]} :
        (AVS_ADDRESS == OFS_STATUS) ?
            {25'h0000000, pend_q, phase_q, flags_q} :
        (AVS_ADDRESS == OFS_CONTROL) ? {31'h00000000, ie_q} :
        (AVS_ADDRESS == OFS_ACC) ? {24'h000000, acc_q} : 32'h00000000;

    // one-cycle answer; a page write waits while one is still queued
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            wait_q <= 1'b1;
            rdata_q <= 32'h00000000;
        end else begin
            wait_q <= !accept;
            if (accept) begin
                rdata_q <= rd_mux;
            end
        end
    end

    // low-byte write queued until the next instruction boundary
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            pcl_pend_q <= 1'b0;
            pcl_val_q <= 8'h00;
        end else if (wr_now && pcl_sel) begin
            pcl_pend_q <= 1'b1;
            pcl_val_q <= AVS_WRITEDATA[7:0];
        end else if (pcl_apply) begin
            pcl_pend_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign AVS_READDATA = rdata_q;
    assign AVS_WAITREQUEST = wait_q;
    assign PM_ADDR = pc_q;
    assign PHASE_CLK = phase_oh_q;
    assign INT_ACK = ack_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (!ARST_N);

    sequence s_branch;
        boundary && (is_jump || is_call) && !pcl_pend_q;
    endsequence

    sequence s_dummy_cycle;
        !ir_valid_q [*4];
    endsequence

    a_phase_order: assert property (
        phase_q == PH_WRITE |=> phase_q == PH_FETCH ##1
            phase_q == PH_DECODE ##1 phase_q == PH_EXEC)
        else $error("phase order broken");

    a_phase_clocks: assert property (
        $onehot(phase_oh_q) && phase_oh_q == (4'h1 << phase_q))
        else $error("phase clocks overlap or mismatch");

    a_pc_step: assert property (
        boundary && !redirect |=> pc_q == $past(pc_q) + 11'h001)
        else $error("counter did not step by one");

    a_branch_two: assert property (
        s_branch |=> s_dummy_cycle ##0 boundary)
        else $error("branch not followed by dummy cycle");

    a_skip_discard: assert property (
        skip_take && !pcl_pend_q |=> !ir_valid_q &&
            pc_q == $past(pc_q) + 11'h001)
        else $error("taken skip kept prefetched word");

    a_page_write: assert property (
        pcl_apply |=> !ir_valid_q && pc_q[7:0] == $past(pcl_val_q) &&
            pc_q[PC_W-1:8] == $past(pc_q[PC_W-1:8]))
        else $error("page write mishandled");

    a_int_inhibit: assert property (
        stack_full && pend_q |-> !int_take ##1 (!INT_ACK && pend_q))
        else $error("interrupt acknowledged on full stack");

    a_int_entry: assert property (
        int_take |=> INT_ACK && pc_q == INT_VECTOR ##1 !INT_ACK)
        else $error("interrupt entry wrong");

    a_call_full: assert property (
        is_call && stack_full |=> depth_q == 3'(STACK_DEPTH) &&
            wp_q == $past(wp_q) + 2'b01)
        else $error("call on full stack misbehaved");

endmodule
`default_nettype wire

/* File: prog_mem_model.sv */
// program memory model holding the test program
`timescale 1ns/1ns
`default_nettype none
module prog_mem_model
    import seq_pkg::*;
(
    input wire logic [PC_W-1:0] addr,
    output logic [INSN_W-1:0] data
);
    // 2K words of 14 bits, unused words hold a no-operation
    logic [INSN_W-1:0] mem [2048];
    // ------------------------------------------------------------
    // test program
    // ------------------------------------------------------------
    initial begin
        for (int i = 0; i < 2048; i++) begin
            mem[i] = 14'h3000;
        end
        mem[11'h000] = 14'h0F35;
        mem[11'h001] = 14'h0010;
        mem[11'h002] = 14'h07FF;
        mem[11'h003] = 14'h050F;
        mem[11'h004] = 14'h0650;
        mem[11'h005] = 14'h0D00;
        mem[11'h006] = 14'h1006;
        mem[11'h010] = 14'h0F05;
        mem[11'h011] = 14'h0207;
        mem[11'h012] = 14'h1012;
        mem[11'h020] = 14'h0F01;
        mem[11'h021] = 14'h2300;
        mem[11'h022] = 14'h0FAA;
        mem[11'h023] = 14'h1023;
        mem[11'h030] = 14'h1840;
        mem[11'h031] = 14'h1031;
        mem[11'h040] = 14'h0F77;
        mem[11'h041] = 14'h3001;
        mem[11'h050] = 14'h1860;
        mem[11'h060] = 14'h1862;
        mem[11'h061] = 14'h1061;
        mem[11'h062] = 14'h1864;
        mem[11'h063] = 14'h3001;
        mem[11'h064] = 14'h1866;
        mem[11'h065] = 14'h3001;
        mem[11'h066] = 14'h1868;
        mem[11'h067] = 14'h3001;
        mem[11'h068] = 14'h3001;
        mem[11'h070] = 14'h1872;
        mem[11'h072] = 14'h1874;
        mem[11'h074] = 14'h1876;
        mem[11'h076] = 14'h1878;
        mem[11'h077] = 14'h1077;
        mem[11'h078] = 14'h1078;
        mem[11'h079] = 14'h3001;
        mem[11'h080] = 14'h3002;
        mem[11'h0F0] = 14'h1100;
        mem[11'h100] = 14'h1100;
        mem[11'h120] = 14'h1120;
    end
    // word follows the address at once; the sequencer samples late
    assign data = mem[addr];
endmodule
`default_nettype wire

/* File: fetch_sequencer_tb.sv */
// self-checking bench for the fetch sequencer
`timescale 1ns/1ns
`default_nettype none
module fetch_sequencer_tb
    import seq_pkg::*;
;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [PC_W-1:0] pm_addr;
    logic [INSN_W-1:0] pm_data;
    logic [3:0] phase_clk;
    logic int_req = 1'b0;
    logic int_ack;
    logic [31:0] rd;
    logic [10:0] exp_a;
    int n_fail = 0;
    int checks = 0;
    int hits;
    // ------------------------------------------------------------
    // clock, design and program memory
    // ------------------------------------------------------------
    always #50 mclk = ~mclk;
    fetch_sequencer #(.INT_VECTOR(11'h080)) dut_u (
        .MCLK(mclk), .ARST_N(arst_n), .AVS_ADDRESS(avs_address),
        .AVS_READ(avs_read), .AVS_WRITE(avs_write),
        .AVS_WRITEDATA(avs_writedata), .AVS_READDATA(avs_readdata),
        .AVS_WAITREQUEST(avs_waitrequest), .PM_ADDR(pm_addr),
        .PM_DATA(pm_data), .PHASE_CLK(phase_clk),
        .INT_REQ(int_req), .INT_ACK(int_ack));
    prog_mem_model pm_u (.addr(pm_addr), .data(pm_data));
    // ------------------------------------------------------------
    // compares, bus cycles and waits
    // ------------------------------------------------------------
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t word %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_addr(input logic [10:0] exp);
        checks++;
        if (pm_addr !== exp) begin
            n_fail++;
            $display("ERROR %0t fetch %h expected %h", $time, pm_addr, exp);
        end
    endtask
    // one access, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [3:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= ~wr;
        do begin
            @(posedge mclk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        rd = avs_readdata;
        if (n >= 50) begin
            n_fail++;
            $display("ERROR %0t bus access not answered", $time);
        end
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk_word(rd, exp);
    endtask
    // wait for a fetch address, then let the loop settle
    task automatic wait_addr(input logic [10:0] a);
        int n;
        n = 0;
        while (pm_addr !== a && n < 400) begin
            @(posedge mclk);
            n++;
        end
        chk_addr(a);
        repeat (8) @(posedge mclk);
    endtask
    task automatic do_reset();
        @(posedge mclk);
        arst_n <= 1'b0;
        repeat (10) @(posedge mclk);
        chk_addr(11'h000);
        chk_word({28'h0, phase_clk}, 32'h1);
        chk_word({30'h0, avs_waitrequest, int_ack}, 32'h2);
        arst_n <= 1'b1;
    endtask
    task automatic report_and_stop();
        if (n_fail == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (30000) @(posedge mclk);
        n_fail++;
        report_and_stop();
    end
    // ------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------
    initial begin
        do_reset();
        // phases rotate; fetch steps by one, jump to self costs two
        for (int i = 0; i < 40; i++) begin
            @(posedge mclk);
            chk_word({28'h0, phase_clk}, 32'h1 << (i % 4));
            exp_a = (i < 28) ? 11'(i / 4) : 11'(6 + ((i / 4 - 6) % 2));
            if (i % 4 == 0) chk_addr(exp_a);
        end
        rd_chk(OFS_ACC, 32'h5B);
        bus(1'b1, OFS_ACC, 32'h11);
        rd_chk(OFS_ACC, 32'h5B);
        for (int a = 0; a < 16; a++) begin
            if (a % 4 != 0) rd_chk(4'(a), 32'h0);
        end
        bus(1'b1, OFS_PC_LOW, 32'h10);
        wait_addr(11'h012);
        rd_chk(OFS_ACC, 32'hFE);
        bus(1'b0, OFS_STATUS, 32'h0);
        chk_word(rd & 32'h1, 32'h0);
        bus(1'b1, OFS_PC_LOW, 32'h20);
        wait_addr(11'h023);
        rd_chk(OFS_ACC, 32'h00);
        bus(1'b1, OFS_PC_LOW, 32'h30);
        wait_addr(11'h041);
        wait_addr(11'h031);
        rd_chk(OFS_ACC, 32'h77);
        // fill the stack, then raise an interrupt that must wait
        bus(1'b1, OFS_CONTROL, 32'h1);
        rd_chk(OFS_CONTROL, 32'h1);
        bus(1'b1, OFS_PC_LOW, 32'h70);
        wait_addr(11'h078);
        int_req <= 1'b1;
        @(posedge mclk);
        int_req <= 1'b0;
        hits = 0;
        repeat (40) begin
            @(posedge mclk);
            if (int_ack === 1'b1) hits++;
        end
        chk_word(32'(hits), 32'h0);
        bus(1'b0, OFS_STATUS, 32'h0);
        chk_word(rd & 32'h40, 32'h40);
        bus(1'b1, OFS_PC_LOW, 32'h79);
        hits = 0;
        while (int_ack !== 1'b1 && hits < 100) begin
            @(posedge mclk);
            hits++;
        end
        chk_word({31'h0, int_ack}, 32'h1);
        chk_addr(11'h080);
        // a second reset empties the stack; five nested calls follow
        do_reset();
        bus(1'b1, OFS_PC_LOW, 32'h50);
        wait_addr(11'h061);
        wait_addr(11'h061);
        bus(1'b1, OFS_PC_LOW, 32'hF0);
        wait_addr(11'h100);
        bus(1'b1, OFS_PC_LOW, 32'h20);
        wait_addr(11'h120);
        bus(1'b0, OFS_PC_LOW, 32'h0);
        chk_word(rd & 32'hFFFFFFFE, 32'h20);
        report_and_stop();
    end
endmodule
`default_nettype wire
